/* File: hw/video_capture_consts.svh */
// Shared constants of the parallel video port: bus slices, timing codes and source timing
`ifndef VIDEO_CAPTURE_CONSTS_SVH
`define VIDEO_CAPTURE_CONSTS_SVH

// Widths
`define BUS_W      24
`define CW         12
// Timing reference codes and their lanes
`define CODE_FF    8'hFF
`define CODE_00    8'h00
`define TRS_MSB    11
`define TRS_LSB    4
`define XY_F       6
`define XY_V       5
`define XY_H       4
`define TRS_LAST   2'd3
// 4:4:4 24-bit lanes
`define B_MSB      7
`define B_LSB      0
`define G_MSB      15
`define G_LSB      8
`define R_MSB      23
`define R_LSB      16
// 4:4:4 12-bit half words and 4:2:2 luma/chroma lanes
`define HALF_MSB   11
`define HALF_LSB   0
`define LUMA_MSB   11
`define CHROMA_MSB 23
`define L16_LSB    4
`define L20_LSB    2
`define L24_LSB    0
`define C16_LSB    16
`define C20_LSB    14
`define C24_LSB    12
// Source pixel clock divider: half period of four clk_in cycles
`define SRC_LAST   3'd3
`define SRC_DECIDE 3'd0
// Source line and frame timing, counted in bus words and lines
`define H_ACT      8'd16
`define H_BLK      8'd8
`define HS_W       8'd4
`define TRS_LEN    8'd4
`define V_ACT      4'd4
`define V_TOT      4'd6

`endif

/* File: hw/video_pkg.sv */
// Types shared by both ends of the parallel video port
package video_pkg;
    `include "video_capture_consts.svh"

    // Input format selected by software
    typedef enum logic [2:0] {FMT_444_24, FMT_444_12, FMT_422_16, FMT_422_20, FMT_422_24} fmt_t;

    // One captured pixel
    typedef struct packed {
        logic [`CW-1:0] cr;
        logic [`CW-1:0] y;
        logic [`CW-1:0] cb;
        logic           odd;
    } pix_t;

    // Capture end state
    typedef struct packed {
        logic           prev_clk;
        logic [1:0]     trs_cnt;
        logic           fld;
        logic           vbl;
        logic           hbl;
        logic           act;
        logic           odd;
        logic           ddr_hi;
        logic [`CW-1:0] lo_half;
        pix_t           ent0;
        pix_t           ent1;
        logic           v0;
        logic           v1;
        logic           lsync;
        logic           fsync;
        logic           ovf;
    } cap_state_t;

    // Source line phases; the phase names the next word to send
    typedef enum logic [1:0] {PH_ACT, PH_EAV, PH_HBLK, PH_SAV} src_phase_t;

    // Source end state
    typedef struct packed {
        logic              pclk;
        logic [2:0]        hcnt;
        logic              tick;
        logic              rdy;
        src_phase_t        phase;
        logic [7:0]        wcnt;
        logic [3:0]        line;
        logic              odd;
        logic              hi;
        logic [`CW-1:0]    hi_half;
        logic [`BUS_W-1:0] data;
        logic              ls;
        logic              fs;
        logic              av;
        logic              unr;
    } src_state_t;
endpackage

/* File: hw/video_bus_if.sv */
// Parallel video bus between a video source and the capture port
`timescale 1ns/1ps
`include "video_capture_consts.svh"
interface video_bus_if;
    logic              pix_clk;            // Pixel clock level, sampled by clk_in
    logic [`BUS_W-1:0] data;               // Pixel data lanes
    logic              line_sync;          // Line sync, grounded with embedded syncs
    logic              frame_sync;         // Frame sync, grounded with embedded syncs
    logic              active_video_flag;  // Active video, grounded with embedded syncs

    modport source  (output pix_clk, data, line_sync, frame_sync, active_video_flag);
    modport capture (input  pix_clk, data, line_sync, frame_sync, active_video_flag);
endinterface

/* File: hw/parallel_video_input_capture.sv */
// Capture end of the parallel video port: edge select, lane unpacking, embedded sync decode, buffer
// Functional notes
// - 24-bit 4:4:4: whole pixel, B/G/R lanes
// - 4:2:2: luma every clock, one chroma
// - 4:2:2: even pixels Cb, odd pixels Cr
// - Source keeps active intervals even length
// - 16-bit: luma D11..D4, chroma D23..D16
// - 20-bit: luma D11..D2, chroma D23..D14
// - 24-bit 4:2:2: luma D11..D0, chroma D23..D12
// - Embedded syncs: sync pins grounded, timing in data
// - Detect FF 00 00 XY on D11..D4
// - 20-bit embedded mode matches BT1120 20-bit
// - Source grounds unused data lanes
// - Format set by configuration, no autodetect
// - Sample on configured pixel clock edge
// - Dual edge: word on both edges
// - 12-bit dual edge input supported
// - 1X single rate, 0.5X double rate
// - Double rate embedded uses same mapping
`timescale 1ns/1ps
`include "video_capture_consts.svh"
module parallel_video_input_capture
    import video_pkg::*;
(
    input  wire logic          clk_in,          // System clock
    input  wire logic          rst_n_in,        // Async reset
    video_bus_if.capture       bus,             // Video bus from source
    input  wire video_pkg::fmt_t fmt_in,        // Input format
    input  wire logic          embedded_in,     // Syncs carried in data
    input  wire logic          edge_sel_in,     // 0 rising, 1 falling
    input  wire logic          dual_edge_in,    // Capture on both edges
    input  wire logic          pix_ready_in,    // Receiver accepts pixel
    output logic               pix_valid_out,   // Pixel available
    output logic [`CW-1:0]     y_out,           // Luma or green
    output logic [`CW-1:0]     cb_out,          // Cb or blue
    output logic [`CW-1:0]     cr_out,          // Cr or red
    output logic               odd_out,         // Odd pixel of a 4:2:2 pair
    output logic               line_sync_out,   // Line sync
    output logic               frame_sync_out,  // Frame sync or vertical blank
    output logic               active_out,      // Active video
    output logic               field_out,       // Field flag
    output logic               overflow_out     // Sticky pixel loss
);
    import video_pkg::*;

    cap_state_t        s_reg;      // All state
    cap_state_t        s_next;     // Next state
    logic              rise;       // Pixel clock rose
    logic              fall;       // Pixel clock fell
    logic              take;       // Sample the bus now
    logic              keep;       // Sampled word is a pixel
    logic              xy;         // Sampled word is a timing code XY
    logic              pop;        // Receiver takes head
    logic              can_push;   // Buffer has room
    logic              push;       // Pixel to store
    logic [7:0]        w;          // Timing code lanes
    logic [`CW-1:0]    yv;         // Unpacked luma
    logic [`CW-1:0]    cv;         // Unpacked chroma
    logic [`BUS_W-1:0] full;       // Rebuilt 12-bit dual edge pixel
    pix_t              px;         // Pixel being built

    // Next state: edge detect, unpacking, sync decode and buffer
    always_comb begin
        s_next   = s_reg;
        rise     = bus.pix_clk & ~s_reg.prev_clk;
        fall     = ~bus.pix_clk & s_reg.prev_clk;
        keep     = 1'b0;
        xy       = 1'b0;
        push     = 1'b0;
        yv       = '0;
        cv       = '0;
        full     = '0;
        px       = '0;
        w        = bus.data[`TRS_MSB:`TRS_LSB];
        pop      = s_reg.v0 & pix_ready_in;
        can_push = ~(s_reg.v0 & s_reg.v1) | pop;
        s_next.prev_clk = bus.pix_clk;
        // Edge choice: both edges give 0.5X clocking, one edge gives 1X
        if (dual_edge_in) begin
            take = rise | fall;
        end else begin
            take = edge_sel_in ? fall : rise;
        end
        if (take) begin
            if (embedded_in) begin
                // Sync pins ignored; timing from codes in the stream
                xy = (s_reg.trs_cnt == `TRS_LAST);
                if (xy) begin
                    // Decode field, vertical and horizontal flags
                    s_next.fld     = w[`XY_F];
                    s_next.vbl     = w[`XY_V];
                    s_next.hbl     = w[`XY_H];
                    s_next.act     = ~w[`XY_V] & ~w[`XY_H];
                    s_next.trs_cnt = '0;
                end else if (w == `CODE_FF) begin
                    s_next.trs_cnt = 2'd1;
                end else if (w == `CODE_00 && s_reg.trs_cnt != 2'd0) begin
                    s_next.trs_cnt = s_reg.trs_cnt + 2'd1;
                end else begin
                    s_next.trs_cnt = '0;
                end
                s_next.lsync = s_next.hbl;
                s_next.fsync = s_next.vbl;
                // FF and 00 are reserved codes, never video
                keep = s_reg.act & ~xy & (w != `CODE_FF) & (w != `CODE_00);
            end else begin
                // Separate syncs taken from the pins
                s_next.lsync   = bus.line_sync;
                s_next.fsync   = bus.frame_sync;
                s_next.act     = bus.active_video_flag;
                s_next.fld     = 1'b0;
                s_next.trs_cnt = '0;
                keep           = bus.active_video_flag;
            end
            if (keep) begin
                // Lane unpacking follows the configured format only
                case (fmt_in)
                    FMT_444_24: begin
                        px.cb = `CW'(bus.data[`B_MSB:`B_LSB]);
                        px.y  = `CW'(bus.data[`G_MSB:`G_LSB]);
                        px.cr = `CW'(bus.data[`R_MSB:`R_LSB]);
                        push  = 1'b1;
                    end
                    FMT_444_12: begin
                        // Low half first, high half on the next edge
                        if (!s_reg.ddr_hi) begin
                            s_next.lo_half = bus.data[`HALF_MSB:`HALF_LSB];
                            s_next.ddr_hi  = 1'b1;
                        end else begin
                            full   = {bus.data[`HALF_MSB:`HALF_LSB], s_reg.lo_half};
                            px.cb  = `CW'(full[`B_MSB:`B_LSB]);
                            px.y   = `CW'(full[`G_MSB:`G_LSB]);
                            px.cr  = `CW'(full[`R_MSB:`R_LSB]);
                            push   = 1'b1;
                            s_next.ddr_hi = 1'b0;
                        end
                    end
                    default: begin
                        // 4:2:2: luma each word, chroma alternates
                        if (fmt_in == FMT_422_16) begin
                            yv = `CW'(bus.data[`LUMA_MSB:`L16_LSB]);
                            cv = `CW'(bus.data[`CHROMA_MSB:`C16_LSB]);
                        end else if (fmt_in == FMT_422_20) begin
                            yv = `CW'(bus.data[`LUMA_MSB:`L20_LSB]);
                            cv = `CW'(bus.data[`CHROMA_MSB:`C20_LSB]);
                        end else begin
                            yv = bus.data[`LUMA_MSB:`L24_LSB];
                            cv = bus.data[`CHROMA_MSB:`C24_LSB];
                        end
                        px.y   = yv;
                        px.odd = s_reg.odd;
                        if (s_reg.odd) begin
                            px.cr = cv;
                        end else begin
                            px.cb = cv;
                        end
                        s_next.odd = ~s_reg.odd;
                        push       = 1'b1;
                    end
                endcase
            end
            // Pair position restarts with each active interval
            if (!s_next.act) begin
                s_next.odd    = 1'b0;
                s_next.ddr_hi = 1'b0;
            end
        end
        // Two-entry buffer; head always sits in entry 0
        if (pop) begin
            s_next.ent0 = s_reg.ent1;
            s_next.v0   = s_reg.v1;
            s_next.v1   = 1'b0;
        end
        if (push) begin
            if (!can_push) begin
                s_next.ovf = 1'b1;  // Word lost, sticky until reset
            end else if (!s_next.v0) begin
                s_next.ent0 = px;
                s_next.v0   = 1'b1;
            end else begin
                s_next.ent1 = px;
                s_next.v1   = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from state flops
    assign pix_valid_out  = s_reg.v0;
    assign y_out          = s_reg.ent0.y;
    assign cb_out         = s_reg.ent0.cb;
    assign cr_out         = s_reg.ent0.cr;
    assign odd_out        = s_reg.ent0.odd;
    assign line_sync_out  = s_reg.lsync;
    assign frame_sync_out = s_reg.fsync;
    assign active_out     = s_reg.act;
    assign field_out      = s_reg.fld;
    assign overflow_out   = s_reg.ovf;
endmodule

/* File: hw/video_source_driver.sv */
// Source end of the parallel video port: pixel clock divider, line timing, lane packing
`timescale 1ns/1ps
`include "video_capture_consts.svh"
module video_source_driver
    import video_pkg::*;
(
    input  wire logic            clk_in,        // System clock
    input  wire logic            rst_n_in,      // Async reset
    video_bus_if.source          bus,           // Video bus to capture
    input  wire video_pkg::fmt_t fmt_in,        // Output format
    input  wire logic            embedded_in,   // Put syncs in data
    input  wire logic            edge_sel_in,   // Capture edge: 0 rising, 1 falling
    input  wire logic            dual_edge_in,  // Word on both edges
    input  wire logic            px_valid_in,   // User pixel present
    output logic                 px_ready_out,  // Pixel taken when valid
    input  wire logic [`CW-1:0]  y_in,          // Luma or green
    input  wire logic [`CW-1:0]  cb_in,         // Cb or blue
    input  wire logic [`CW-1:0]  cr_in,         // Cr or red
    output logic                 underrun_out   // Sticky missing pixel
);
    import video_pkg::*;

    src_state_t     s_reg;   // All state
    src_state_t     s_next;  // Next state
    logic           vact;    // Current line is active
    logic           tk;      // Pixel taken this tick
    logic [`CW-1:0] cv;      // Chroma for this pixel
    logic [7:0]     code;    // Timing code word

    // Next state: divider, word scheduling and packing
    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        s_next.rdy  = 1'b0;
        vact        = (s_reg.line < `V_ACT);
        tk          = s_reg.rdy & px_valid_in;
        cv          = s_reg.odd ? cr_in : cb_in;
        code        = '0;
        // Pixel clock divider
        if (s_reg.hcnt == `SRC_LAST) begin
            s_next.hcnt = '0;
            s_next.pclk = ~s_reg.pclk;
        end else begin
            s_next.hcnt = s_reg.hcnt + 3'd1;
        end
        // Schedule a word mid-phase, away from the capture edge
        if (s_reg.hcnt == `SRC_DECIDE && (dual_edge_in || s_reg.pclk == edge_sel_in)) begin
            s_next.tick = 1'b1;
            s_next.rdy  = (s_reg.phase == PH_ACT) && vact && !(fmt_in == FMT_444_12 && s_reg.hi);
        end
        if (s_reg.tick) begin
            if (s_reg.rdy && !px_valid_in) begin
                s_next.unr = 1'b1;
            end
            // Unused lanes and, when embedded, sync pins stay grounded
            s_next.data = '0;
            s_next.av   = 1'b0;
            s_next.ls   = 1'b0;
            s_next.fs   = ~embedded_in & ~vact;
            s_next.wcnt = s_reg.wcnt + 8'd1;
            case (s_reg.phase)
                PH_ACT: begin
                    if (vact) begin
                        s_next.av = ~embedded_in;
                        // Packing follows the configured format
                        if (fmt_in == FMT_444_12 && s_reg.hi) begin
                            s_next.data[`HALF_MSB:`HALF_LSB] = s_reg.hi_half;
                            s_next.hi = 1'b0;
                        end else if (tk && fmt_in == FMT_444_24) begin
                            s_next.data = {cr_in[`B_MSB:0], y_in[`B_MSB:0], cb_in[`B_MSB:0]};
                        end else if (fmt_in == FMT_444_12) begin
                            // Missing pixel still sends both halves as zeros, so word pairs stay aligned
                            s_next.hi      = 1'b1;
                            s_next.hi_half = '0;
                            if (tk) begin
                                s_next.data[`HALF_MSB:`HALF_LSB] = {y_in[3:0], cb_in[`B_MSB:0]};
                                s_next.hi_half = {cr_in[`B_MSB:0], y_in[`B_MSB:4]};
                            end
                        end else if (tk && fmt_in == FMT_422_16) begin
                            s_next.data[`LUMA_MSB:`L16_LSB]   = y_in[`B_MSB:0];
                            s_next.data[`CHROMA_MSB:`C16_LSB] = cv[`B_MSB:0];
                        end else if (tk && fmt_in == FMT_422_20) begin
                            s_next.data[`LUMA_MSB:`L20_LSB]   = y_in[9:0];
                            s_next.data[`CHROMA_MSB:`C20_LSB] = cv[9:0];
                        end else if (tk) begin
                            s_next.data = {cv, y_in};
                        end
                        if (fmt_in != FMT_444_24 && fmt_in != FMT_444_12) begin
                            s_next.odd = ~s_reg.odd;
                        end
                    end
                    // Active run is an even word count, so pairs close
                    if (s_reg.wcnt == `H_ACT - 8'd1) begin
                        s_next.phase = PH_EAV;
                        s_next.wcnt  = '0;
                        s_next.odd   = 1'b0;
                    end
                end
                PH_EAV, PH_SAV: begin
                    // FF 00 00 XY with F=0 and protection bits
                    if (s_reg.wcnt == 8'd0) begin
                        code = `CODE_FF;
                    end else if (s_reg.wcnt == 8'd3) begin
                        code = {1'b1, 1'b0, ~vact, (s_reg.phase == PH_EAV), ~vact ^ (s_reg.phase == PH_EAV),
                                (s_reg.phase == PH_EAV), ~vact, ~vact ^ (s_reg.phase == PH_EAV)};
                    end else begin
                        code = `CODE_00;
                    end
                    if (embedded_in) begin
                        s_next.data[`TRS_MSB:`TRS_LSB] = code;
                    end
                    if (s_reg.wcnt == `TRS_LEN - 8'd1) begin
                        s_next.wcnt  = '0;
                        s_next.phase = (s_reg.phase == PH_EAV) ? PH_HBLK : PH_ACT;
                        if (s_reg.phase == PH_EAV) begin
                            s_next.line = (s_reg.line == `V_TOT - 4'd1) ? 4'd0 : s_reg.line + 4'd1;
                        end
                    end
                end
                default: begin
                    // Horizontal blank with line sync pulse at its start
                    s_next.ls = ~embedded_in & (s_reg.wcnt < `HS_W);
                    if (s_reg.wcnt == `H_BLK - 8'd1) begin
                        s_next.wcnt  = '0;
                        s_next.phase = PH_SAV;
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from state flops
    assign bus.pix_clk           = s_reg.pclk;
    assign bus.data              = s_reg.data;
    assign bus.line_sync         = s_reg.ls;
    assign bus.frame_sync        = s_reg.fs;
    assign bus.active_video_flag = s_reg.av;
    assign px_ready_out          = s_reg.rdy;
    assign underrun_out          = s_reg.unr;
endmodule

/* File: verification/parallel_video_input_capture_properties.sv */
// Wire checks on the video bus between source and capture ends
`timescale 1ns/1ps
`include "video_capture_consts.svh"
module parallel_video_input_capture_properties
    import video_pkg::*;
(
    input  wire logic              clk_in,             // System clock
    input  wire logic              rst_n_in,           // Async reset
    input  wire logic              pix_clk,            // Pixel clock level
    input  wire logic [`BUS_W-1:0] data,               // Data lanes
    input  wire logic              line_sync,          // Line sync pin
    input  wire logic              frame_sync,         // Frame sync pin
    input  wire logic              active_video_flag,  // Active video pin
    input  wire video_pkg::fmt_t   fmt_in,             // Bus format
    input  wire logic              embedded_in,        // Syncs in data
    input  wire logic              dual_edge_in        // Word on both edges
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0] act_cnt_reg;  // Clocks of the current active run

    // Length of each active run, cleared while the flag is low
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            act_cnt_reg <= 8'h00;
        end else begin
            act_cnt_reg <= active_video_flag ? act_cnt_reg + 8'h01 : 8'h00;
        end
    end

    a_embedded_pins_low: assert property (embedded_in |-> !(line_sync | frame_sync | active_video_flag))
        else $error("sync pin driven in embedded mode");
    a_lanes16_grounded: assert property (fmt_in == FMT_422_16 |-> data[3:0] == 0 && data[15:12] == 0)
        else $error("unused 16-bit lane driven");
    a_lanes20_grounded: assert property (fmt_in == FMT_422_20 |-> data[1:0] == 0 && data[13:12] == 0)
        else $error("unused 20-bit lane driven");
    a_half_lanes_unused: assert property (fmt_in == FMT_444_12 |-> data[23:12] == 0)
        else $error("upper lanes driven in 12-bit mode");
    a_active_run_even: assert property ($fell(active_video_flag) |->
        (dual_edge_in ? act_cnt_reg[2:0] == 0 : act_cnt_reg[3:0] == 0))
        else $error("active run of odd word count");
    a_stable_at_edge: assert property ($changed(pix_clk) |->
        $stable({data, line_sync, frame_sync, active_video_flag}))
        else $error("bus changed on a pixel clock edge");
    a_pix_clk_half: assert property ($changed(pix_clk) |=> $stable(pix_clk) [*3])
        else $error("pixel clock half period short");
    a_data_hold_time: assert property ($changed(data) |=> $stable(data) [*3])
        else $error("data word held too briefly");
endmodule

/* File: verification/parallel_video_input_capture_tb_top.sv */
// Bench joining source and capture ends, pixels compared at the receiver side
`timescale 1ns/1ps
module parallel_video_input_capture_tb_top;
    import video_pkg::*;
    logic        clk_in, rst_n_in, embedded, edge_sel, dual, px_valid, px_ready, pix_valid, pix_ready;
    logic        stall, odd_out, ls_out, fs_out, act_out, fld_out, ovf_out, unr_out;
    logic [11:0] y_in, cb_in, cr_in, y_out, cb_out, cr_out, mask;
    logic [35:0] w;                   // Pixel as noted before lane masking
    fmt_t        fmt;                 // Format under test
    int          num_errors = 0, checked = 0, parity, pops, fs_seen, ls_seen, av_seen, miss, seed;
    logic [36:0] exp_q[$];            // Expected {y, cb, cr, odd}
    video_bus_if vb();
    video_source_driver i_video_source_driver (.clk_in, .rst_n_in, .bus(vb), .fmt_in(fmt), .embedded_in(embedded),
        .edge_sel_in(edge_sel), .dual_edge_in(dual), .px_valid_in(px_valid), .px_ready_out(px_ready),
        .y_in, .cb_in, .cr_in, .underrun_out(unr_out));
    parallel_video_input_capture i_parallel_video_input_capture (.clk_in, .rst_n_in, .bus(vb), .fmt_in(fmt),
        .embedded_in(embedded), .edge_sel_in(edge_sel), .dual_edge_in(dual), .pix_ready_in(pix_ready),
        .pix_valid_out(pix_valid), .y_out, .cb_out, .cr_out, .odd_out, .line_sync_out(ls_out),
        .frame_sync_out(fs_out), .active_out(act_out), .field_out(fld_out), .overflow_out(ovf_out));
    parallel_video_input_capture_properties i_parallel_video_input_capture_properties (.clk_in, .rst_n_in,
        .pix_clk(vb.pix_clk), .data(vb.data), .line_sync(vb.line_sync), .frame_sync(vb.frame_sync),
        .active_video_flag(vb.active_video_flag), .fmt_in(fmt), .embedded_in(embedded), .dual_edge_in(dual));

    // Clock of 10 ns
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input string what, input logic [36:0] seen, input logic [36:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Note the pixel taken in each slot, then present new random user inputs
    always @(posedge clk_in) begin
        // Embedded: the run before the first timing code is never captured
        if (rst_n_in && px_ready && (!embedded || ls_seen > 0)) begin
            w = px_valid ? {y_in, cb_in, cr_in} : 36'h0_0000_0000;
            if (fmt >= FMT_422_16 && parity[0]) w[23:12] = 12'h000;
            else if (fmt >= FMT_422_16) w[11:0] = 12'h000;
            exp_q.push_back({w, fmt >= FMT_422_16 && parity[0]});
            parity++;
            miss += !px_valid;
        end
        #1;
        mask = (fmt == FMT_422_24) ? 12'hFFF : (fmt == FMT_422_20) ? 12'h3FF : 12'h0FF;
        // Embedded: a zero word would read as a reserved code and be dropped
        px_valid = embedded || ($urandom % 8) != 0;
        pix_ready = !stall && ($urandom % 8) != 0;
        y_in = $urandom & mask;
        // Embedded: luma on the code lanes never reads FF or 00
        if (embedded) y_in = (y_in & (mask >> 1)) | ((mask >> 2) + 12'h001);
        cb_in = $urandom & mask;
        cr_in = $urandom & mask;
    end

    // Pop the oldest note whenever the receiver takes a pixel
    always @(posedge clk_in) begin
        if (rst_n_in && pix_valid && pix_ready) begin
            pops++;
            if (exp_q.size() == 0) check("pixel count", 0, 1);
            else check("pixel", {y_out, cb_out, cr_out, odd_out}, exp_q.pop_front());
        end
        if (rst_n_in) begin
            fs_seen += fs_out;
            ls_seen += ls_out;
            av_seen += act_out;
        end
    end

    // Every format and edge mode, embedded syncs for 4:2:2 formats only, then a receiver stall
    initial begin
        {rst_n_in, stall, px_valid, pix_ready, embedded, edge_sel, dual} = 7'h00;
        {y_in, cb_in, cr_in} = 36'h0_0000_0000;
        fmt = FMT_444_24;
        seed = $urandom(47);
        for (int f = 0; f < 5; f++) begin
            for (int c = 0; c < 6; c++) begin
                if (c < 3 || f >= 2) begin
                    @(posedge clk_in);
                    #1 rst_n_in = 1'b0;
                    fmt = fmt_t'(f);
                    {embedded, edge_sel, dual} = {c >= 3, c % 3 == 1, c % 3 == 2};
                    exp_q.delete();
                    {parity, pops, fs_seen, ls_seen, av_seen, miss} = '0;
                    repeat (20) @(posedge clk_in);
                    #1 rst_n_in = 1'b1;
                    repeat (1700) @(posedge clk_in);
                    check("pixels flowed", pops > 8, 1);
                    check("syncs regenerated", {fs_seen > 0, ls_seen > 0, av_seen > 0}, 3'h7);
                    check("field", fld_out, 0);
                    check("underrun", unr_out, miss > 0);
                    check("overflow clear", ovf_out, 0);
                end
            end
        end
        stall = 1'b1;
        repeat (400) @(posedge clk_in);
        check("overflow set", {ovf_out, pix_valid}, 2'h3);
        print_verdict();
    end

    // Cut a hang short
    initial begin
        #800000;
        num_errors++;
        print_verdict();
    end
endmodule
